// ### rtl/pv_frame_ctrl.sv
// Frame control, shadowing and register access of the preview engine
//
// Contract
// - Memory source always runs one frame, run cleared
// - Memory source starts at once on run
// - Front end source follows its frame start
// - Run cleared mid-frame stops after frame
// - One interrupt and DMA event per frame
// - Busy sets at frame start only if run
// - Busy clears with DMA event when safe
// - Interrupt only after output data landed
// - Late dark data flag, write one clears
// - Single frame start resets run, single, source
// - Shadowed registers apply at frame start
// - Control plus six path registers are shadowed
// - Gain registers writable while busy, act immediately
// - Averager and table registers ignore writes while busy
// - Table reads while busy undefined, no strobes
// - Table index advances per access unless busy
// - Table port 20 bits, narrow tables 8
module pv_frame_ctrl #(
   parameter int TBL_DEPTH = pv_pkg::TBL_DEPTH_DEF
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [pv_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [pv_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic SOF_IN,
   input wire logic FRAME_DONE_IN,
   input wire logic LANDED_IN,
   input wire logic DARK_LATE_IN,
   output logic BUSY,
   output logic DMA_EVENT,
   output logic FRAME_IRQ,
   output logic MEM_FETCH_START,
   output logic DARK_LATE,
   output pv_pkg::frame_cfg_t WORK_CFG,
   output logic [31:0] WHITE_BAL_DIGITAL_GAIN,
   output logic [31:0] WHITE_BAL_CHANNEL_GAIN,
   output logic [7:0] AVERAGER_SETTING
);
   import pv_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   generate
      if (TBL_DEPTH < 1 || TBL_DEPTH > (1 << TBL_AW)) begin : g_bad_depth
         $error("TBL_DEPTH does not fit the table index");
      end
   endgenerate

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      frm_state_t frm;                                  // Frame sequencer
      logic land_pend;                                  // Frame output still landing
      logic dma_ev;                                     // DMA event pulse
      logic irq;                                        // Interrupt pulse
      logic mem_start;                                  // Memory fetch start pulse
      logic dark_late;                                  // Sticky late dark data flag
      ctrl_t ctrl_sh;                                   // Software view of control bits
      path_cfg_t paths_sh;                              // Software view of path registers
      frame_cfg_t work;                                 // Copy used by the current frame
      logic [31:0] dgain;                               // Digital gain, live
      logic [31:0] cgain;                               // Channel gain, live
      logic [7:0] avg;                                  // Averager setting, locked
      logic [TBL_AW-1:0] tidx;                          // Table index, locked
      logic awready;                                    // Write address and data accepted
      logic bvalid;                                     // Write answer pending
      logic [1:0] bresp;                                // Write answer code
      logic arready;                                    // Read address accepted
      logic rstage;                                     // Read waiting for table data
      logic [ADDR_W-1:0] raddr;                         // Captured read address
      logic rvalid;                                     // Read answer pending
      logic [31:0] rdata;                               // Read answer data
      logic [1:0] rresp;                                // Read answer code
   } st_t;

   st_t q;                                              // Registered state
   st_t d;                                              // Next state
   logic busy;                                          // Frame in progress
   logic wr_fire;                                       // Write taken this cycle
   logic rd_fire;                                       // Read taken this cycle
   logic sof;                                           // Frame starts this cycle
   logic mem_we;                                        // Table write strobe
   logic [TBL_W-1:0] mem_wdata;                         // Table write data
   logic [TBL_W-1:0] mem_rdata;                         // Table read data

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // True for an index inside the full-width table
   function automatic logic is_wide(input logic [TBL_AW-1:0] idx);
      return (idx >= ENH_FIRST) && (idx <= ENH_LAST);
   endfunction

   // True for any mapped register offset
   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      return (a[1:0] == 2'h0) && (a <= OFF_TDATA);
   endfunction

   // ----------------------------------------
   // Table memory
   // ----------------------------------------
   pv_table_mem #(
      .DEPTH(TBL_DEPTH),
      .AW(TBL_AW),
      .W(TBL_W)
   ) u_tbl (
      .clk(CLK),
      .we(mem_we),
      .addr(q.tidx),
      .wdata(mem_wdata),
      .rdata(mem_rdata)
   );

   assign busy = q.frm[1];                              // One-hot busy code bit, straight from its flop
   assign wr_fire = q.awready;
   assign rd_fire = q.arready;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Frame sequencing, bus slave and register updates
   always_comb begin
      d = q;
      d.dma_ev = 1'b0;
      d.irq = 1'b0;
      d.mem_start = 1'b0;
      d.awready = 1'b0;
      d.arready = 1'b0;
      mem_we = 1'b0;
      mem_wdata = '0;
      // Memory source starts at once, front end waits for its frame start
      sof = q.ctrl_sh.run && !busy && (q.ctrl_sh.source || SOF_IN);
      // Interrupt once the previous frame has landed
      if (q.land_pend && LANDED_IN) begin
         d.irq = 1'b1;
         d.land_pend = 1'b0;
      end
      // Frame sequencer
      unique case (q.frm)
         FR_IDLE: begin
            if (sof) begin
               d.frm = FR_BUSY;
               d.work = {q.ctrl_sh, q.paths_sh};
               d.mem_start = q.ctrl_sh.source;
               // One-shot returns control bits to reset values
               if (q.ctrl_sh.single || q.ctrl_sh.source) begin
                  d.ctrl_sh = CTRL_RST;
               end
            end
         end
         FR_BUSY: begin
            // Run cleared mid-frame only takes effect at the next start
            if (FRAME_DONE_IN) begin
               d.frm = FR_IDLE;
               d.dma_ev = 1'b1;
               d.land_pend = 1'b1;
            end
         end
      endcase
      // Write channel: accept address and data together
      if (S_AXI_AWVALID && S_AXI_WVALID && !q.awready && !q.bvalid) begin
         d.awready = 1'b1;
      end
      if (q.bvalid && S_AXI_BREADY) begin
         d.bvalid = 1'b0;
      end
      if (wr_fire) begin
         d.bvalid = 1'b1;
         d.bresp = is_mapped(S_AXI_AWADDR) ? RESP_OKAY : RESP_SLVERR;
         unique case (S_AXI_AWADDR)
            OFF_CTRL: begin
               // Shadow only, the frame copy changes at the next start
               if (S_AXI_WSTRB[0]) begin
                  d.ctrl_sh.run = S_AXI_WDATA[CTRL_RUN];
                  d.ctrl_sh.single = S_AXI_WDATA[CTRL_SINGLE];
                  d.ctrl_sh.source = S_AXI_WDATA[CTRL_SRC];
                  if (S_AXI_WDATA[CTRL_DARK]) begin
                     d.dark_late = 1'b0;
                  end
               end
            end
            OFF_RD_BASE: d.paths_sh.rd_base = merge(q.paths_sh.rd_base, S_AXI_WDATA,
                                                    S_AXI_WSTRB);
            OFF_RD_PITCH: d.paths_sh.rd_pitch = merge(q.paths_sh.rd_pitch, S_AXI_WDATA,
                                                      S_AXI_WSTRB);
            OFF_DK_BASE: d.paths_sh.dk_base = merge(q.paths_sh.dk_base, S_AXI_WDATA,
                                                    S_AXI_WSTRB);
            OFF_DK_PITCH: d.paths_sh.dk_pitch = merge(q.paths_sh.dk_pitch, S_AXI_WDATA,
                                                      S_AXI_WSTRB);
            OFF_WR_BASE: d.paths_sh.wr_base = merge(q.paths_sh.wr_base, S_AXI_WDATA,
                                                    S_AXI_WSTRB);
            OFF_WR_PITCH: d.paths_sh.wr_pitch = merge(q.paths_sh.wr_pitch, S_AXI_WDATA,
                                                      S_AXI_WSTRB);
            // Gains change at once, even mid-frame
            OFF_DGAIN: d.dgain = merge(q.dgain, S_AXI_WDATA, S_AXI_WSTRB);
            OFF_CGAIN: d.cgain = merge(q.cgain, S_AXI_WDATA, S_AXI_WSTRB);
            // Locked registers silently keep their value while busy
            OFF_AVG: begin
               if (!busy && S_AXI_WSTRB[0]) begin
                  d.avg = S_AXI_WDATA[7:0];
               end
            end
            OFF_TIDX: begin
               if (!busy) begin
                  d.tidx = S_AXI_WDATA[TBL_AW-1:0];
               end
            end
            OFF_TDATA: begin
               if (!busy) begin
                  mem_we = (32'(q.tidx) < TBL_DEPTH);
                  // Narrow tables keep the low byte only
                  mem_wdata = is_wide(q.tidx) ? S_AXI_WDATA[TBL_W-1:0] :
                              {12'h000, S_AXI_WDATA[TBL_NARROW_W-1:0]};
                  d.tidx = q.tidx + 13'h0001;
               end
            end
            default: begin
            end
         endcase
      end
      // Late dark data sets the flag, set wins over a clear
      if (DARK_LATE_IN) begin
         d.dark_late = 1'b1;
      end
      // Read channel: one read at a time
      if (S_AXI_ARVALID && !q.arready && !q.rstage && !q.rvalid) begin
         d.arready = 1'b1;
      end
      if (rd_fire) begin
         d.raddr = S_AXI_ARADDR;
         d.rstage = 1'b1;
         // Table read steps the index unless busy
         if (S_AXI_ARADDR == OFF_TDATA && !busy) begin
            d.tidx = d.tidx + 13'h0001;
         end
      end
      if (q.rstage) begin
         d.rstage = 1'b0;
         d.rvalid = 1'b1;
         d.rresp = is_mapped(q.raddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (q.raddr)
            OFF_CTRL: d.rdata = {27'h0, q.dark_late, busy, q.ctrl_sh.source,
                                 q.ctrl_sh.single, q.ctrl_sh.run};
            OFF_RD_BASE: d.rdata = q.paths_sh.rd_base;
            OFF_RD_PITCH: d.rdata = q.paths_sh.rd_pitch;
            OFF_DK_BASE: d.rdata = q.paths_sh.dk_base;
            OFF_DK_PITCH: d.rdata = q.paths_sh.dk_pitch;
            OFF_WR_BASE: d.rdata = q.paths_sh.wr_base;
            OFF_WR_PITCH: d.rdata = q.paths_sh.wr_pitch;
            OFF_DGAIN: d.rdata = q.dgain;
            OFF_CGAIN: d.rdata = q.cgain;
            OFF_AVG: d.rdata = {24'h000000, q.avg};
            OFF_TIDX: d.rdata = {19'h0, q.tidx};
            // Whole word regardless of strobes, stale while busy
            OFF_TDATA: d.rdata = {12'h000, mem_rdata};
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      if (q.rvalid && S_AXI_RREADY) begin
         d.rvalid = 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // All state resets to constants
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         q <= '{frm: FR_IDLE, ctrl_sh: CTRL_RST, paths_sh: '0, work: '0,
                dgain: REG_RST, cgain: REG_RST, avg: AVG_RST, tidx: TIDX_RST,
                bresp: RESP_OKAY, rresp: RESP_OKAY, rdata: REG_RST, raddr: '0,
                default: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign S_AXI_AWREADY = q.awready;
   assign S_AXI_WREADY = q.awready;
   assign S_AXI_BVALID = q.bvalid;
   assign S_AXI_BRESP = q.bresp;
   assign S_AXI_ARREADY = q.arready;
   assign S_AXI_RVALID = q.rvalid;
   assign S_AXI_RDATA = q.rdata;
   assign S_AXI_RRESP = q.rresp;
   assign BUSY = busy;
   assign DMA_EVENT = q.dma_ev;
   assign FRAME_IRQ = q.irq;
   assign MEM_FETCH_START = q.mem_start;
   assign DARK_LATE = q.dark_late;
   assign WORK_CFG = q.work;
   assign WHITE_BAL_DIGITAL_GAIN = q.dgain;
   assign WHITE_BAL_CHANNEL_GAIN = q.cgain;
   assign AVERAGER_SETTING = q.avg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_busy_needs_run: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(busy) |-> $past(q.ctrl_sh.run))
      else $error("busy rose without run");
   a_mem_single_frame_select: assert property (@(posedge CLK) disable iff (!NRST)
      (sof && q.ctrl_sh.source && !wr_fire) |=> !q.ctrl_sh.run && busy)
      else $error("memory frame left run set");
   a_mem_fetch_now: assert property (@(posedge CLK) disable iff (!NRST)
      (q.ctrl_sh.run && q.ctrl_sh.source && !busy) |=> MEM_FETCH_START)
      else $error("memory fetch did not start at once");
   a_front_wait: assert property (@(posedge CLK) disable iff (!NRST)
      (!busy && !q.ctrl_sh.source && !SOF_IN) |=> !busy)
      else $error("front end frame began without frame start");
   a_frame_holds: assert property (@(posedge CLK) disable iff (!NRST)
      (busy && !FRAME_DONE_IN) |=> busy)
      else $error("frame ended before its done");
   a_dma_at_clear: assert property (@(posedge CLK) disable iff (!NRST)
      $fell(busy) |-> DMA_EVENT ##1 !DMA_EVENT)
      else $error("dma event not tied to busy clear");
   a_irq_after_land: assert property (@(posedge CLK) disable iff (!NRST)
      FRAME_IRQ |-> $past(LANDED_IN) && $past(q.land_pend))
      else $error("interrupt before data landed");
   a_dark_set_wins: assert property (@(posedge CLK) disable iff (!NRST)
      DARK_LATE_IN |=> DARK_LATE)
      else $error("late dark flag lost");
   a_copy_at_start: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(busy) |-> WORK_CFG == $past({q.ctrl_sh, q.paths_sh}))
      else $error("working copy not taken at frame start");
   a_locked_avg: assert property (@(posedge CLK) disable iff (!NRST)
      busy |=> $stable(AVERAGER_SETTING) && $stable(q.tidx))
      else $error("locked register changed while busy");
   a_gain_live: assert property (@(posedge CLK) disable iff (!NRST)
      (wr_fire && S_AXI_AWADDR == OFF_DGAIN && S_AXI_WSTRB == 4'hf)
      |=> WHITE_BAL_DIGITAL_GAIN == $past(S_AXI_WDATA))
      else $error("gain write did not act at once");
endmodule

// ### rtl/pv_pkg.sv
// Shared constants and types for the preview frame control block
package pv_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam int ADDR_W = 8;                           // Register window address width
   localparam logic [7:0] OFF_CTRL = 8'h00;             // engine_control_reg (shadowed)
   localparam logic [7:0] OFF_RD_BASE = 8'h04;          // read_path_base (shadowed)
   localparam logic [7:0] OFF_RD_PITCH = 8'h08;         // read_path_pitch (shadowed)
   localparam logic [7:0] OFF_DK_BASE = 8'h0c;          // dark_path_base (shadowed)
   localparam logic [7:0] OFF_DK_PITCH = 8'h10;         // dark_path_pitch (shadowed)
   localparam logic [7:0] OFF_WR_BASE = 8'h14;          // write_path_base (shadowed)
   localparam logic [7:0] OFF_WR_PITCH = 8'h18;         // write_path_pitch (shadowed)
   localparam logic [7:0] OFF_DGAIN = 8'h1c;            // white_bal_digital_gain (live)
   localparam logic [7:0] OFF_CGAIN = 8'h20;            // white_bal_channel_gain (live)
   localparam logic [7:0] OFF_AVG = 8'h24;              // averager_setting (locked)
   localparam logic [7:0] OFF_TIDX = 8'h28;             // table_index_reg (locked)
   localparam logic [7:0] OFF_TDATA = 8'h2c;            // table_data_port (locked)
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTRL_RUN = 0;                         // Run bit
   localparam int CTRL_SINGLE = 1;                      // single_frame_select
   localparam int CTRL_SRC = 2;                         // Source: 1 memory, 0 front end
   localparam int CTRL_BUSY = 3;                        // Busy status, read only
   localparam int CTRL_DARK = 4;                        // dark_late_flag, write 1 clears
   localparam logic [2:0] CTRL_RST = 3'h0;              // Run, single and source after reset
   localparam logic [31:0] REG_RST = 32'h0000_0000;     // Other registers after reset
   localparam logic [7:0] AVG_RST = 8'h00;              // Averager after reset
   // ----------------------------------------
   // Table memory
   // ----------------------------------------
   localparam int TBL_AW = 13;                          // Table index width
   localparam int TBL_DEPTH_DEF = 5880;                 // Entries up to the last coefficient
   localparam int TBL_W = 20;                           // Table data port width
   localparam int TBL_NARROW_W = 8;                     // Bits used by narrow tables
   localparam logic [12:0] ENH_FIRST = 13'h1000;        // First wide (enhancement) entry
   localparam logic [12:0] ENH_LAST = 13'h107f;         // Last wide entry
   localparam logic [12:0] TIDX_RST = 13'h0000;         // Table index after reset
   // ----------------------------------------
   // Bus answers
   // ----------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;             // Normal answer
   localparam logic [1:0] RESP_SLVERR = 2'h2;           // Unmapped address
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic source;                                     // 1 = frames from memory
      logic single;                                     // 1 = one frame only
      logic run;                                        // Run request
   } ctrl_t;
   typedef struct packed {
      logic [31:0] rd_base;
      logic [31:0] rd_pitch;
      logic [31:0] dk_base;
      logic [31:0] dk_pitch;
      logic [31:0] wr_base;
      logic [31:0] wr_pitch;
   } path_cfg_t;
   typedef struct packed {
      ctrl_t ctrl;
      path_cfg_t paths;
   } frame_cfg_t;
   typedef enum logic [1:0] {
      FR_IDLE = 2'b01,                                  // Waiting for a start of frame
      FR_BUSY = 2'b10                                   // Frame in progress
   } frm_state_t;
endpackage

// ### rtl/pv_table_mem.sv
// Table memory behind the table data port, no reset on its contents
module pv_table_mem #(
   parameter int DEPTH = 5880,
   parameter int AW = 13,
   parameter int W = 20
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] rdata
);
   logic [W-1:0] mem [DEPTH];                           // Table storage

   // Synchronous write and read, one cycle of read latency
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// ### bench/pv_partner.sv
// Model of the front end and output pipeline around the frame control
module pv_partner (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic BUSY,
   output logic SOF_IN,
   output logic FRAME_DONE_IN,
   output logic LANDED_IN
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt_q; // Free frame timing
   logic [5:0] age_q; // Cycles spent busy
   logic [3:0] land_q; // Done to landed delay line
   // ----------------------------------------
   // Frame timing and pipeline completion
   // ----------------------------------------
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         cnt_q <= 5'h00;
         age_q <= 6'h00;
         land_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 5'h01;
         age_q <= BUSY ? age_q + 6'h01 : 6'h00;
         land_q <= {land_q[2:0], FRAME_DONE_IN};
      end
   end
   // Free-running front end, engine is enabled before frames matter
   // Frame geometry and colour order are taken as legal
   assign SOF_IN = (cnt_q == 5'h1f);
   assign FRAME_DONE_IN = BUSY && (age_q == 6'h28);
   assign LANDED_IN = land_q[3];
endmodule

// ### bench/test_pv_frame_ctrl.sv
// Register-level tests of the preview frame control
module test_pv_frame_ctrl;
   import pv_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLK, NRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
   logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, SOF_IN;
   logic FRAME_DONE_IN, LANDED_IN, DARK_LATE_IN, BUSY, DMA_EVENT, FRAME_IRQ, DARK_LATE;
   logic MEM_FETCH_START;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, AVERAGER_SETTING;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, WHITE_BAL_DIGITAL_GAIN, d;
   logic [31:0] WHITE_BAL_CHANNEL_GAIN;
   logic [3:0] S_AXI_WSTRB;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
   frame_cfg_t WORK_CFG;
   int err_count, n_tests, k, n_fetch;
   pv_frame_ctrl i_pv_frame_ctrl (.CLK, .NRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
      .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
      .S_AXI_RVALID, .S_AXI_RREADY, .SOF_IN, .FRAME_DONE_IN, .LANDED_IN, .DARK_LATE_IN, .BUSY,
      .DMA_EVENT, .FRAME_IRQ, .MEM_FETCH_START, .DARK_LATE, .WORK_CFG, .WHITE_BAL_DIGITAL_GAIN,
      .WHITE_BAL_CHANNEL_GAIN, .AVERAGER_SETTING);
   pv_partner i_pv_partner (.CLK, .NRST, .BUSY, .SOF_IN, .FRAME_DONE_IN, .LANDED_IN);
   // Memory fetch starts seen over the whole run
   always @(posedge CLK) begin
      if (MEM_FETCH_START) n_fetch <= n_fetch + 1;
   end
   always #10 CLK = ~CLK;
   // Bus write, both channels offered together, response held for
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, v, 3'h7};
      do @(posedge CLK); while (!S_AXI_AWREADY);
      {S_AXI_AWVALID, S_AXI_WVALID} <= 2'h0;
      do @(posedge CLK); while (!S_AXI_BVALID);
      resp = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
   endtask
   // Bus read, data taken at the answering edge
   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
      do @(posedge CLK); while (!S_AXI_ARREADY);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK); while (!S_AXI_RVALID);
      d = S_AXI_RDATA;
      resp = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {CLK, NRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, DARK_LATE_IN} = 0;
      S_AXI_WSTRB = 4'hf;
      repeat (10) @(posedge CLK);
      NRST <= 1'b1;
      rd(OFF_CTRL); chk("ctrl reset", 32'h0, d);
      wr(OFF_CTRL, 32'h5);
      rd(OFF_CTRL); chk("ctrl one shot", 32'h8, d);
      chk("work ctrl", 32'h5, WORK_CFG.ctrl);
      wr(OFF_AVG, 32'h33); wr(OFF_DGAIN, 32'h77);
      chk("dgain live", 32'h77, WHITE_BAL_DIGITAL_GAIN);
      wr(OFF_CGAIN, 32'h55); chk("cgain live", 32'h55, WHITE_BAL_CHANNEL_GAIN);
      rd(OFF_AVG); chk("avg locked", 32'h0, d);
      chk("avg pin locked", 32'h0, AVERAGER_SETTING);
      do @(posedge CLK); while (BUSY);
      chk("dma event", 32'h1, DMA_EVENT);
      k = 0;
      repeat (10) begin @(posedge CLK); k += FRAME_IRQ; end
      chk("irq count", 32'h1, k); chk("single frame", 32'h0, BUSY);
      wr(OFF_AVG, 32'h33); rd(OFF_AVG); chk("avg free", 32'h33, d);
      chk("avg pin free", 32'h33, AVERAGER_SETTING);
      wr(OFF_WR_BASE, 32'h200);
      wr(OFF_CTRL, 32'h1);
      do @(posedge CLK); while (!BUSY);
      chk("work wr base", 32'h200, WORK_CFG.paths.wr_base);
      rd(OFF_CTRL); chk("run kept", 32'h9, d);
      wr(OFF_RD_BASE, 32'h100); wr(OFF_CTRL, 32'h0);
      chk("frame runs on", 32'h1, BUSY);
      rd(OFF_RD_BASE); chk("shadow read", 32'h100, d);
      rd(OFF_TDATA);
      chk("work unchanged", 32'h0, WORK_CFG.paths.rd_base);
      do @(posedge CLK); while (BUSY);
      repeat (40) @(posedge CLK);
      chk("stopped", 32'h0, BUSY);
      rd(OFF_TIDX); chk("index held", 32'h0, d);
      DARK_LATE_IN <= 1'b1; @(posedge CLK); DARK_LATE_IN <= 1'b0;
      rd(OFF_CTRL); chk("dark set", 32'h10, d);
      chk("dark pin", 32'h1, DARK_LATE);
      wr(OFF_CTRL, 32'h10); rd(OFF_CTRL); chk("dark clear", 32'h0, d);
      wr(OFF_TIDX, 32'hfff); wr(OFF_TDATA, 32'habcde); wr(OFF_TDATA, 32'h12345);
      wr(OFF_TIDX, 32'hfff); rd(OFF_TDATA); chk("narrow", 32'hde, d);
      rd(OFF_TDATA); chk("wide", 32'h12345, d);
      rd(OFF_TIDX); chk("index steps", 32'h1001, d);
      wr(8'h40, 32'h1); chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
      rd(8'h40); chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, resp});
      chk("fetch count", 32'h1, n_fetch);
      close_out();
   end
   initial begin
      repeat (3000) @(posedge CLK);
      err_count++;
      close_out();
   end
endmodule
